// >>> wtm_pkg.sv
// Purpose: Shared constants and types of the waveform trigger and marker block.
// Assumes: 32-bit AXI4-Lite register access, one aligned word per register.
// Notes: Sample words pack two 16-bit raw samples, marker bits in the two LSBs.
package wtm_pkg;
    localparam int AXI_AW = 8;
    localparam int AXI_DW = 32;
    localparam int NUM_TRIG = 4;
    localparam int NUM_SRC = 4;
    localparam int SAMPLE_W = 16;
    localparam int ANALOG_W = 14;
    localparam int MARKER_W = 2;
    localparam int FIFO_DEPTH = 4;

    // Register byte offsets.
    localparam logic [AXI_AW-1:0] OFS_TRIG_CFG = 8'h00;
    localparam logic [AXI_AW-1:0] OFS_CONN_CFG = 8'h04;
    localparam logic [AXI_AW-1:0] OFS_INSTR = 8'h08;
    localparam logic [AXI_AW-1:0] OFS_SAMPLE = 8'h0C;
    localparam logic [AXI_AW-1:0] OFS_STATUS = 8'h10;

    // Trigger configuration: two source bits per channel, then one slope bit per channel.
    localparam int TCFG_SLOPE_POS = 8;
    localparam logic [11:0] TCFG_RST = 12'hFE4;
    // Connector configuration fields.
    localparam int CCFG_DRIVE_POS = 4;
    localparam logic [4:0] CCFG_RST = 5'h00;
    localparam logic [1:0] CONN_MARKER1 = 2'h0;
    localparam logic [1:0] CONN_TRIG1 = 2'h1;
    localparam logic [1:0] CONN_OSC = 2'h2;

    // Instruction word fields, then the connector oscillator select bit.
    localparam int OP_POS = 28;
    localparam logic [3:0] OP_WAIT_EDGE = 4'h1;
    localparam logic [3:0] OP_PLAY = 4'h2;
    localparam logic [3:0] OP_WAIT_DONE = 4'h3;
    localparam logic [3:0] OP_LOAD_TRIG = 4'h4;
    localparam int OSC_SEL_POS = 2;

    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;
    localparam logic [15:0] PLAY_CNT_RST = 16'h0000;

    typedef enum logic [1:0] {
        SEQ_FETCH = 2'b00,
        SEQ_WAIT_EDGE = 2'b01,
        SEQ_WAIT_DONE = 2'b10
    } wtm_seq_t;
endpackage

// >>> wtm_top.sv
// Purpose: Trigger inputs, marker outputs, trigger outputs and connector routing of a sequencer.
// Assumes: All pins and oscillator levels are asynchronous and synchronised here.
// Notes: Instructions and samples are written over AXI4-Lite; full targets stall the write response.
//
// Functional notes
// - Four independent digital trigger channels the sequencer can wait on.
// - Each channel selects its source from front pins or internal signals.
// - Wait-edge instruction stalls until a qualifying edge on its channel source.
// - Each sample is 16 bits: 14 analog bits and 2 marker bits.
// - Marker outputs follow each played sample, aligned with its analog value.
// - Marker code 0 none, 1 first, 2 second, 3 both markers high.
// - Waveforms without explicit markers carry zero marker bits.
// - Summed waveforms add analog parts and OR their marker bits.
// - Load-trigger puts a 4-bit value on outputs, bit 0 driving output 1.
// - Wait-playback-done holds the sequencer until playback has fully completed.
// - Trigger output loaded before a playback rises when the load executes, ahead of that playback's start.
// - Connector two can output marker one with its driver enabled.
// - Connector two can instead output trigger output one.
// - Connector two can output a square wave from a selected oscillator.
// - A playback instruction only starts playback; the sequencer continues meanwhile.
// - Raw samples are unsigned, markers in the two LSBs, 0 negative full scale.
`timescale 1ns/1ps

module wtm_fifo #(
    parameter int WIDTH = 32,
    parameter int DEPTH = 4
) (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic in_valid,
    output logic in_ready,
    input wire logic [WIDTH-1:0] in_data,
    output logic out_valid,
    input wire logic out_ready,
    output logic [WIDTH-1:0] out_data
);
    localparam int PW = $clog2(DEPTH);
    logic [WIDTH-1:0] mem_r [DEPTH];
    logic [PW-1:0] wr_ptr_r;
    logic [PW-1:0] rd_ptr_r;
    logic [PW:0] count_r;
    wire push = in_valid && in_ready;
    wire pop = out_valid && out_ready;

    assign in_ready = (count_r != (PW+1)'(DEPTH));
    assign out_valid = (count_r != '0);
    assign out_data = mem_r[rd_ptr_r];

    always_ff @(posedge aclk) begin
        if (push) begin
            mem_r[wr_ptr_r] <= in_data;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            wr_ptr_r <= '0;
            rd_ptr_r <= '0;
            count_r <= '0;
        end else begin
            if (push) begin
                wr_ptr_r <= (wr_ptr_r == PW'(DEPTH-1)) ? '0 : wr_ptr_r + 1'b1;
            end
            if (pop) begin
                rd_ptr_r <= (rd_ptr_r == PW'(DEPTH-1)) ? '0 : rd_ptr_r + 1'b1;
            end
            count_r <= count_r + (PW+1)'(push) - (PW+1)'(pop);
        end
    end
endmodule

module wtm_top (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic [wtm_pkg::AXI_AW-1:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [wtm_pkg::AXI_DW-1:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [wtm_pkg::AXI_AW-1:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [wtm_pkg::AXI_DW-1:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic [1:0] trig_pin_in,
    input wire logic [1:0] osc_in,
    output logic conn2_out,
    output logic conn2_oe,
    output logic [wtm_pkg::NUM_TRIG-1:0] trig_out,
    output logic [wtm_pkg::MARKER_W-1:0] marker_out,
    output logic [wtm_pkg::ANALOG_W-1:0] analog_out,
    output logic sample_valid
);
    import wtm_pkg::*;

    function automatic logic pick_src(input logic [NUM_SRC-1:0] v, input logic [1:0] sel);
        pick_src = v[sel];
    endfunction

    // Offset-binary 14-bit code to signed and back is an MSB flip.
    function automatic logic signed [ANALOG_W:0] to_signed(input logic [SAMPLE_W-1:0] s);
        to_signed = {{2{~s[SAMPLE_W-1]}}, s[SAMPLE_W-2:MARKER_W]};
    endfunction

    // Register file and bus state.
    logic [11:0] trig_cfg_r;
    logic [4:0] conn_cfg_r;
    logic aw_got_r;
    logic w_got_r;
    logic [AXI_AW-1:0] awaddr_r;
    logic [AXI_DW-1:0] wdata_r;
    logic [3:0] wstrb_r;
    logic awready_r;
    logic wready_r;
    logic bvalid_r;
    logic [1:0] bresp_r;
    logic arready_r;
    logic rvalid_r;
    logic [1:0] rresp_r;
    logic [AXI_DW-1:0] rdata_r;

    // Sequencer state.
    wtm_seq_t state_r;
    logic [AXI_DW-1:0] instr_r;
    logic instr_full_r;
    logic [1:0] wait_ch_r;
    logic [15:0] play_cnt_r;
    logic [NUM_TRIG-1:0] trig_r;
    logic [MARKER_W-1:0] marker_r;
    logic [ANALOG_W-1:0] analog_r;
    logic sample_valid_r;
    logic conn_out_r;
    logic conn_oe_r;

    // Source synchronisers: first stage feeds only the second.
    logic [NUM_SRC-1:0] src_s1_r;
    logic [NUM_SRC-1:0] src_s2_r;
    logic [NUM_SRC-1:0] src_prev_r;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            src_s1_r <= '0;
            src_s2_r <= '0;
            src_prev_r <= '0;
        end else begin
            src_s1_r <= {osc_in, trig_pin_in};
            src_s2_r <= src_s1_r;
            src_prev_r <= src_s2_r;
        end
    end

    // Per-channel source choice and edge qualification.
    logic [NUM_TRIG-1:0] edge_hit;
    genvar gi;
    generate
        for (gi = 0; gi < NUM_TRIG; gi++) begin : g_chan
            wire [1:0] sel = trig_cfg_r[2*gi +: 2];
            wire cur = pick_src(src_s2_r, sel);
            wire prv = pick_src(src_prev_r, sel);
            wire rise = trig_cfg_r[TCFG_SLOPE_POS + gi];
            assign edge_hit[gi] = rise ? (cur && !prv) : (!cur && prv);
        end
    endgenerate

    // Write channel decode.
    wire wr_go = aw_got_r && w_got_r && !bvalid_r;
    wire sel_tcfg = (awaddr_r == OFS_TRIG_CFG);
    wire sel_ccfg = (awaddr_r == OFS_CONN_CFG);
    wire sel_instr = (awaddr_r == OFS_INSTR);
    wire sel_sample = (awaddr_r == OFS_SAMPLE);
    wire wr_mapped = sel_tcfg || sel_ccfg || sel_instr || sel_sample;
    wire fifo_in_ready;
    // A full target holds the response back, which is how software is throttled.
    wire wr_target_ok = !(sel_instr && instr_full_r) && !(sel_sample && !fifo_in_ready);
    wire wr_fire = wr_go && wr_target_ok;
    wire fifo_push = wr_fire && sel_sample;
    wire aw_take = s_axi_awvalid && awready_r;
    wire w_take = s_axi_wvalid && wready_r;
    wire aw_got_nxt = wr_fire ? 1'b0 : (aw_got_r || aw_take);
    wire w_got_nxt = wr_fire ? 1'b0 : (w_got_r || w_take);
    wire bvalid_nxt = wr_fire || (bvalid_r && !s_axi_bready);

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_got_r <= 1'b0;
            w_got_r <= 1'b0;
            awaddr_r <= '0;
            wdata_r <= '0;
            wstrb_r <= '0;
            awready_r <= 1'b0;
            wready_r <= 1'b0;
            bvalid_r <= 1'b0;
            bresp_r <= RESP_OKAY;
        end else begin
            aw_got_r <= aw_got_nxt;
            w_got_r <= w_got_nxt;
            awready_r <= !aw_got_nxt && !bvalid_nxt;
            wready_r <= !w_got_nxt && !bvalid_nxt;
            bvalid_r <= bvalid_nxt;
            if (aw_take) begin
                awaddr_r <= {s_axi_awaddr[AXI_AW-1:2], 2'b00};
            end
            if (w_take) begin
                wdata_r <= s_axi_wdata;
                wstrb_r <= s_axi_wstrb;
            end
            if (wr_fire) begin
                bresp_r <= wr_mapped ? RESP_OKAY : RESP_SLVERR;
            end
        end
    end

    // Configuration registers honour byte strobes.
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            trig_cfg_r <= TCFG_RST;
            conn_cfg_r <= CCFG_RST;
        end else if (wr_fire) begin
            if (sel_tcfg && wstrb_r[0]) begin
                trig_cfg_r[7:0] <= wdata_r[7:0];
            end
            if (sel_tcfg && wstrb_r[1]) begin
                trig_cfg_r[11:8] <= wdata_r[11:8];
            end
            if (sel_ccfg && wstrb_r[0]) begin
                conn_cfg_r <= wdata_r[4:0];
            end
        end
    end

    // Read channel.
    wire [AXI_AW-1:0] raddr = {s_axi_araddr[AXI_AW-1:2], 2'b00};
    wire playing = (play_cnt_r != PLAY_CNT_RST);
    wire [AXI_DW-1:0] status_w = {22'h000000, marker_r, trig_r, playing, state_r == SEQ_WAIT_DONE,
                                  state_r == SEQ_WAIT_EDGE, instr_full_r};
    wire r_hit_t = (raddr == OFS_TRIG_CFG);
    wire r_hit_c = (raddr == OFS_CONN_CFG);
    wire r_hit_s = (raddr == OFS_STATUS);
    wire r_wo = (raddr == OFS_INSTR) || (raddr == OFS_SAMPLE);
    wire [AXI_DW-1:0] rd_mux = r_hit_t ? {20'h00000, trig_cfg_r} :
                              r_hit_c ? {27'h0000000, conn_cfg_r} :
                              r_hit_s ? status_w : 32'h00000000;
    wire ar_take = s_axi_arvalid && arready_r;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            arready_r <= 1'b0;
            rvalid_r <= 1'b0;
            rresp_r <= RESP_OKAY;
            rdata_r <= '0;
        end else if (ar_take) begin
            arready_r <= 1'b0;
            rvalid_r <= 1'b1;
            rdata_r <= rd_mux;
            rresp_r <= (r_hit_t || r_hit_c || r_hit_s || r_wo) ? RESP_OKAY : RESP_SLVERR;
        end else if (rvalid_r && s_axi_rready) begin
            rvalid_r <= 1'b0;
            arready_r <= 1'b1;
        end else begin
            arready_r <= !rvalid_r;
        end
    end

    // Sample FIFO between the bus and the playback engine.
    wire fifo_out_valid;
    wire [AXI_DW-1:0] fifo_out_data;
    wire pop = playing && fifo_out_valid;

    wtm_fifo #(
        .WIDTH(AXI_DW),
        .DEPTH(FIFO_DEPTH)
    ) u_fifo (
        .aclk(aclk),
        .aresetn(aresetn),
        .in_valid(fifo_push),
        .in_ready(fifo_in_ready),
        .in_data(wdata_r),
        .out_valid(fifo_out_valid),
        .out_ready(pop),
        .out_data(fifo_out_data)
    );

    // Two raw samples per word are summed: analog saturates, markers are ORed.
    wire [SAMPLE_W-1:0] samp_a = fifo_out_data[SAMPLE_W-1:0];
    wire [SAMPLE_W-1:0] samp_b = fifo_out_data[AXI_DW-1:SAMPLE_W];
    wire signed [ANALOG_W:0] sum_s = to_signed(samp_a) + to_signed(samp_b);
    wire sum_hi = (sum_s[ANALOG_W] == 1'b0) && (sum_s[ANALOG_W-1] == 1'b1);
    wire sum_lo = (sum_s[ANALOG_W] == 1'b1) && (sum_s[ANALOG_W-1] == 1'b0);
    wire [ANALOG_W-1:0] sum_sat = sum_hi ? {1'b0, {(ANALOG_W-1){1'b1}}} :
                                  sum_lo ? {1'b1, {(ANALOG_W-1){1'b0}}} : sum_s[ANALOG_W-1:0];
    wire [ANALOG_W-1:0] analog_nxt = {~sum_sat[ANALOG_W-1], sum_sat[ANALOG_W-2:0]};
    wire [MARKER_W-1:0] marker_nxt = samp_a[MARKER_W-1:0] | samp_b[MARKER_W-1:0];

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            analog_r <= '0;
            marker_r <= '0;
            sample_valid_r <= 1'b0;
        end else begin
            sample_valid_r <= pop;
            if (pop) begin
                analog_r <= analog_nxt;
                marker_r <= marker_nxt;
            end
        end
    end

    // Sequencer decode.
    wire [3:0] op = instr_r[AXI_DW-1:OP_POS];
    wire is_wait_edge = instr_full_r && (op == OP_WAIT_EDGE);
    wire is_play = instr_full_r && (op == OP_PLAY);
    wire is_wait_done = instr_full_r && (op == OP_WAIT_DONE);
    wire is_load = instr_full_r && (op == OP_LOAD_TRIG);
    // A new playback waits for the previous one; anything else is taken at once in the fetch state.
    wire take_instr = (state_r == SEQ_FETCH) && instr_full_r && !(is_play && playing);
    wire start_play = take_instr && is_play;
    wire load_exec = take_instr && is_load;
    wire play_done = playing && pop && (play_cnt_r == 16'h0001);
    wire edge_ok = edge_hit[wait_ch_r];

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            instr_r <= '0;
            instr_full_r <= 1'b0;
        end else if (wr_fire && sel_instr) begin
            instr_r <= wdata_r;
            instr_full_r <= 1'b1;
        end else if (take_instr) begin
            instr_full_r <= 1'b0;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            state_r <= SEQ_FETCH;
            wait_ch_r <= '0;
        end else begin
            unique case (state_r)
                SEQ_FETCH: begin
                    if (take_instr && is_wait_edge) begin
                        state_r <= SEQ_WAIT_EDGE;
                        wait_ch_r <= instr_r[1:0];
                    end else if (take_instr && is_wait_done) begin
                        state_r <= SEQ_WAIT_DONE;
                    end
                end
                SEQ_WAIT_EDGE: begin
                    // Only edges seen from the cycle after entry count.
                    if (edge_ok) begin
                        state_r <= SEQ_FETCH;
                    end
                end
                SEQ_WAIT_DONE: begin
                    if (!playing) begin
                        state_r <= SEQ_FETCH;
                    end
                end
                default: begin
                    state_r <= SEQ_FETCH;
                end
            endcase
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            play_cnt_r <= PLAY_CNT_RST;
            trig_r <= '0;
        end else begin
            if (start_play) begin
                play_cnt_r <= instr_r[15:0];
            end else if (pop) begin
                play_cnt_r <= play_cnt_r - 16'h0001;
            end
            if (load_exec) begin
                trig_r <= instr_r[NUM_TRIG-1:0];
            end
        end
    end

    // Connector routing.
    wire osc_sq = src_s2_r[2 + int'(conn_cfg_r[OSC_SEL_POS])];
    wire conn_nxt = (conn_cfg_r[1:0] == CONN_MARKER1) ? marker_r[0] :
                    (conn_cfg_r[1:0] == CONN_TRIG1) ? trig_r[0] :
                    (conn_cfg_r[1:0] == CONN_OSC) ? osc_sq : 1'b0;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            conn_out_r <= 1'b0;
            conn_oe_r <= 1'b0;
        end else begin
            conn_out_r <= conn_nxt;
            conn_oe_r <= conn_cfg_r[CCFG_DRIVE_POS];
        end
    end

    assign s_axi_awready = awready_r;
    assign s_axi_wready = wready_r;
    assign s_axi_bvalid = bvalid_r;
    assign s_axi_bresp = bresp_r;
    assign s_axi_arready = arready_r;
    assign s_axi_rvalid = rvalid_r;
    assign s_axi_rresp = rresp_r;
    assign s_axi_rdata = rdata_r;
    assign trig_out = trig_r;
    assign marker_out = marker_r;
    assign analog_out = analog_r;
    assign sample_valid = sample_valid_r;
    assign conn2_out = conn_out_r;
    assign conn2_oe = conn_oe_r;

    a_wait_edge_hold: assert property (@(posedge aclk) disable iff (!aresetn)
        (state_r == SEQ_WAIT_EDGE) && !edge_ok |=> (state_r == SEQ_WAIT_EDGE))
        else $error("wait left without a qualifying edge");
    a_wait_edge_go: assert property (@(posedge aclk) disable iff (!aresetn)
        (state_r == SEQ_WAIT_EDGE) && edge_ok |=> (state_r == SEQ_FETCH))
        else $error("qualifying edge did not release the wait");
    a_trig_load_val: assert property (@(posedge aclk) disable iff (!aresetn)
        load_exec |=> (trig_out == $past(instr_r[3:0])) && !instr_full_r)
        else $error("trigger outputs do not match loaded value");
    a_play_no_stall: assert property (@(posedge aclk) disable iff (!aresetn)
        start_play |=> (state_r == SEQ_FETCH) && (play_cnt_r == $past(instr_r[15:0])))
        else $error("playback start stalled the sequencer");
    a_done_waits: assert property (@(posedge aclk) disable iff (!aresetn)
        (state_r == SEQ_WAIT_DONE) && playing |=> (state_r == SEQ_WAIT_DONE))
        else $error("wait for playback released during playback");
    a_done_release: assert property (@(posedge aclk) disable iff (!aresetn)
        play_done && (state_r == SEQ_WAIT_DONE) |=> ##1 (state_r == SEQ_FETCH))
        else $error("wait for playback not released after completion");
    a_marker_or_merge: assert property (@(posedge aclk) disable iff (!aresetn)
        pop |=> sample_valid && (marker_out == ($past(samp_a[1:0]) | $past(samp_b[1:0]))))
        else $error("marker bits not merged by OR");
    a_conn_marker_route: assert property (@(posedge aclk) disable iff (!aresetn)
        (conn_cfg_r[1:0] == CONN_MARKER1) && $stable(conn_cfg_r) |=> (conn2_out == $past(marker_r[0])))
        else $error("connector does not follow marker one");
    a_conn_trig_route: assert property (@(posedge aclk) disable iff (!aresetn)
        (conn_cfg_r[1:0] == CONN_TRIG1) && $stable(conn_cfg_r) |=> (conn2_out == $past(trig_r[0])))
        else $error("connector does not follow trigger one");
endmodule

// >>> wtm_ext_src.sv
// Purpose: Model of the external trigger source and oscillators facing the trigger pins.
// Assumes: Pin and oscillator levels are asynchronous to aclk.
// Notes: The oscillator runs only while osc_run is high.
`timescale 1ns/1ps
module wtm_ext_src (
    input wire logic aclk,
    input wire logic osc_run,
    output logic [1:0] trig_pin,
    output logic [1:0] osc
);
    int div;
    initial begin
        trig_pin = 2'h0;
        osc = 2'h1;
        div = 0;
    end
    // Levels move 7 ns after the edge, so the design must synchronise them.
    task automatic set_pin(input int ch, input logic lvl);
        @(posedge aclk);
        #7 trig_pin[ch] = lvl;
    endtask
    always @(posedge aclk) begin
        if (osc_run) begin
            div <= div + 1;
            if (div % 8 == 7) begin
                osc <= #3 ~osc;
            end
        end
    end
endmodule

// >>> wtm_top_tb.sv
// Purpose: Self-checking bench of the trigger and marker block.
// Assumes: Registers are reached over AXI4-Lite; one transfer at a time.
// Notes: Played samples are compared with a queue-based model.
`timescale 1ns/1ps
module wtm_top_tb;
    import wtm_pkg::*;
    logic aclk, aresetn, osc_run, cnt_en;
    logic [AXI_AW-1:0] s_axi_awaddr, s_axi_araddr;
    logic [AXI_DW-1:0] s_axi_wdata, s_axi_rdata, d;
    logic [3:0] s_axi_wstrb, trig_out, v;
    logic [1:0] s_axi_bresp, s_axi_rresp, trig_pin_in, osc_in, marker_out, r;
    logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
    logic s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready, conn2_out, conn2_oe, sample_valid;
    logic [ANALOG_W-1:0] analog_out;
    logic [15:0] a, b;
    logic [15:0] exp_q[$];
    int miscompares, check_count, seen, n_conn, n_osc;

    wtm_top u_wtm_top (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(s_axi_awaddr),
        .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata),
        .s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
        .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
        .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
        .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid),
        .s_axi_rready(s_axi_rready), .trig_pin_in(trig_pin_in), .osc_in(osc_in), .conn2_out(conn2_out),
        .conn2_oe(conn2_oe), .trig_out(trig_out), .marker_out(marker_out), .analog_out(analog_out),
        .sample_valid(sample_valid));
    wtm_ext_src u_wtm_ext_src (.aclk(aclk), .osc_run(osc_run), .trig_pin(trig_pin_in), .osc(osc_in));

    initial begin
        aclk = 1'b0;
        forever #12.5 aclk = ~aclk;
    end

    task automatic chk_word(input logic [31:0] got, input logic [31:0] exp);
        check_count++;
        if (got !== exp) begin
            miscompares++;
            $display("unexpected at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic chk_smp(input logic [15:0] got, input logic [15:0] exp);
        check_count++;
        if (got !== exp) begin
            miscompares++;
            $display("unexpected at %0t: sample %h expected %h", $time, got, exp);
        end
    endtask
    // Offset-binary sum saturates; markers merge by OR.
    function automatic logic [15:0] mix(input logic [15:0] x, input logic [15:0] y);
        int s;
        s = int'(x[15:2]) + int'(y[15:2]) - 8192;
        s = (s < 0) ? 0 : ((s > 16383) ? 16383 : s);
        return {s[13:0], x[1:0] | y[1:0]};
    endfunction
    task automatic axi_wr(input logic [7:0] ad, input logic [31:0] dat, output logic [1:0] resp);
        s_axi_awaddr <= ad;
        s_axi_wdata <= dat;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        forever begin
            @(posedge aclk);
            if (s_axi_awready) s_axi_awvalid <= 1'b0;
            if (s_axi_wready) s_axi_wvalid <= 1'b0;
            if (s_axi_bvalid) begin
                resp = s_axi_bresp;
                s_axi_bready <= 1'b0;
                break;
            end
        end
        @(posedge aclk);
    endtask
    task automatic axi_rd(input logic [7:0] ad, output logic [31:0] dat, output logic [1:0] resp);
        s_axi_araddr <= ad;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        forever begin
            @(posedge aclk);
            if (s_axi_arready) s_axi_arvalid <= 1'b0;
            if (s_axi_rvalid) begin
                dat = s_axi_rdata;
                resp = s_axi_rresp;
                s_axi_rready <= 1'b0;
                break;
            end
        end
        @(posedge aclk);
    endtask
    task automatic instr(input logic [3:0] op, input logic [15:0] arg);
        axi_wr(OFS_INSTR, {op, 12'h000, arg}, r);
    endtask
    task automatic stop_test();
        $display("checks %0d miscompares %0d", check_count, miscompares);
        if (miscompares == 0 && check_count > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask

    always @(posedge aclk) begin
        if (sample_valid === 1'b1) begin
            seen++;
            chk_smp({analog_out, marker_out}, (exp_q.size() > 0) ? exp_q.pop_front() : 16'hXXXX);
            chk_word(trig_out[0], 1'b1);
        end
    end
    always @(conn2_out) if (cnt_en) n_conn++;
    always @(osc_in[0]) if (cnt_en) n_osc++;

    initial begin
        #1ms;
        miscompares++;
        $display("unexpected at %0t: watchdog expired", $time);
        stop_test();
    end

    initial begin
        {s_axi_awaddr, s_axi_araddr, s_axi_wdata, s_axi_awvalid, s_axi_wvalid, s_axi_bready} = '0;
        {s_axi_arvalid, s_axi_rready, osc_run, cnt_en, aresetn} = '0;
        s_axi_wstrb = 4'hF;
        void'($urandom(32'h00ccbdbc));
        repeat (16) @(posedge aclk);
        aresetn <= 1'b1;
        @(posedge aclk);
        axi_rd(OFS_TRIG_CFG, d, r);
        chk_word({r, d[11:0]}, {RESP_OKAY, TCFG_RST});
        axi_rd(OFS_CONN_CFG, d, r);
        chk_word({r, d[29:0]}, {RESP_OKAY, 25'h0000000, CCFG_RST});
        axi_wr(8'h40, 32'h1, r);
        chk_word(r, RESP_SLVERR);
        axi_wr(OFS_STATUS, 32'h1, r);
        chk_word(r, RESP_SLVERR);
        for (int i = 0; i < 5; i++) begin
            v = (i == 0) ? 4'h3 : 4'($urandom);
            instr(OP_LOAD_TRIG, {12'h000, v});
            repeat (4) @(posedge aclk);
            chk_word(trig_out, v);
        end
        u_wtm_ext_src.set_pin(0, 1'b1);
        u_wtm_ext_src.set_pin(0, 1'b0);
        repeat (6) @(posedge aclk);
        instr(OP_WAIT_EDGE, 16'h0000);
        instr(OP_LOAD_TRIG, 16'h000A);
        repeat (20) @(posedge aclk);
        chk_word(trig_out, v);
        u_wtm_ext_src.set_pin(0, 1'b1);
        repeat (10) @(posedge aclk);
        chk_word(trig_out, 4'hA);
        axi_wr(OFS_CONN_CFG, 32'h10 | CONN_MARKER1, r);
        instr(OP_LOAD_TRIG, 16'h0001);
        instr(OP_PLAY, 16'h0004);
        for (int k = 0; k < 4; k++) begin
            // The wait is issued with one sample still owed, so the sequencer must really stall.
            if (k == 3) begin
                instr(OP_WAIT_DONE, 16'h0000);
                instr(OP_LOAD_TRIG, 16'h0000);
                chk_word(trig_out, 4'h1);
                axi_rd(OFS_STATUS, d, r);
                chk_word({r, d[29:0]}, {RESP_OKAY, 20'h00000, a[1:0] | b[1:0], 4'h1, 4'hD});
            end
            a = (k == 1) ? 16'hFFFC : 16'($urandom);
            b = (k == 0) ? 16'h8000 : ((k == 3) ? 16'h8001 : 16'($urandom));
            exp_q.push_back(mix(a, b));
            axi_wr(OFS_SAMPLE, {b, a}, r);
        end
        repeat (10) @(posedge aclk);
        chk_word(seen, 4);
        chk_word(trig_out, 4'h0);
        chk_word({conn2_oe, conn2_out}, 2'h3);
        axi_wr(OFS_CONN_CFG, 32'h10 | CONN_TRIG1, r);
        instr(OP_LOAD_TRIG, 16'h0001);
        repeat (6) @(posedge aclk);
        chk_word({conn2_oe, conn2_out}, 2'h3);
        axi_wr(OFS_CONN_CFG, 32'h13, r);
        repeat (3) @(posedge aclk);
        chk_word({conn2_oe, conn2_out}, 2'h2);
        axi_wr(OFS_CONN_CFG, 32'h10 | CONN_OSC, r);
        cnt_en <= 1'b1;
        osc_run <= 1'b1;
        repeat (200) @(posedge aclk);
        osc_run <= 1'b0;
        repeat (10) @(posedge aclk);
        chk_word(n_conn, n_osc);
        axi_wr(OFS_TRIG_CFG, 32'hFE6, r);
        instr(OP_WAIT_EDGE, 16'h0000);
        instr(OP_LOAD_TRIG, 16'h0005);
        osc_run <= 1'b1;
        repeat (40) @(posedge aclk);
        chk_word(trig_out, 4'h5);
        stop_test();
    end
endmodule
